/* File: epi_defs.svh */
// epi_defs.svh: offsets, field positions, reset values and timing counts
// for the external pin interrupt block.
// assumes: included by bare name; holds definitions only.
`ifndef EPI_DEFS_SVH
`define EPI_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets on the 6-bit I/O address space
// ----------------------------------------------------------------------
`define EPI_ADDR_ASYNC_SENSE 6'h34
`define EPI_ADDR_PIN_SENSE 6'h35
`define EPI_ADDR_FLAGS 6'h3a
`define EPI_ADDR_ENABLES 6'h3b

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define EPI_BIT_ASYNC_EDGE 6
`define EPI_BIT_PIN_ONE 7
`define EPI_BIT_PIN_ZERO 6
`define EPI_BIT_PIN_TWO 5
`define EPI_PIN_ONE_SENSE_HI 3
`define EPI_PIN_ONE_SENSE_LO 2
`define EPI_PIN_ZERO_SENSE_HI 1
`define EPI_PIN_ZERO_SENSE_LO 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EPI_RST_BYTE 8'h00
`define EPI_RST_SENSE 2'h0
`define EPI_RST_BITS3 3'h0

// ----------------------------------------------------------------------
// timing: watchdog oscillator period and core clock period
// ----------------------------------------------------------------------
`define EPI_WDT_PERIOD_NS 1000
`define EPI_CLK_PERIOD_NS 40
`define EPI_WDT_TICK_CYC (`EPI_WDT_PERIOD_NS / `EPI_CLK_PERIOD_NS)
`define EPI_STARTUP_CYC_DEF 64

`endif

/* File: epi_pkg.sv */
// epi_pkg.sv: types shared by the external pin interrupt block.
// assumes: compiled before the modules that import it.
package epi_pkg;

    // sense field codes for pins zero and one
    typedef enum logic [1:0] {
        SENSE_LOW,
        SENSE_ANY,
        SENSE_FALL,
        SENSE_RISE
    } epi_sense_type;

    // wake-up sequencer states
    typedef enum logic [1:0] {
        WK_RUN,
        WK_SAMPLE,
        WK_STARTUP
    } epi_wake_type;

endpackage : epi_pkg

/* File: epi_sync.sv */
// epi_sync.sv: two flip-flop synchroniser for the three interrupt pins.
// assumes: pins are asynchronous to ref_clk; output feeds logic only.
`timescale 1ns/1ns
`default_nettype none

module epi_sync
    import epi_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // pins and synchronised copy
    input wire logic [2:0] pin_raw,
    output logic [2:0] pin_sync
);

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stable;
    } epi_sync_state_type;

    epi_sync_state_type st_q;
    epi_sync_state_type st_d;

    // ------------------------------------------------------------------
    // next state: the first stage is read only by the second
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.meta = pin_raw;
        st_d.stable = st_q.meta;
    end

    // registers; pins idle high, so reset to ones avoids a false fall
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= {3'h7, 3'h7};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pin_sync = st_q.stable;

endmodule : epi_sync

`default_nettype wire

/* File: epi_ext_irq.sv */
// epi_ext_irq.sv: external pin interrupt block with its I/O registers,
// three request lines, edge and level sensing and a power-down wake path.
// assumes: one ref_clk stands for the always-on clock; io_clk_run says
// whether the I/O clock runs; the CPU pulses irq_ack when it vectors.
`timescale 1ns/1ns
`default_nettype none
`include "epi_defs.svh"

// What this block does
// - pins trigger requests even when driven as outputs by the part itself.
// - pin two edge select bit 6: zero falling, one rising; no level.
// - low-level mode keeps requesting while the pin stays low.
// - pin zero/one edges need I/O clock; level and pin-two edges do not.
// - asynchronous detections wake the part from power-down; pin-two edges also from any sleep without I/O clock.
// - power-down level wake needs two watchdog samples, one microsecond apart.
// - level gone before start-up end: wake, but raise no level interrupt.
// - pin one sense bits 3:2: low, any change, falling, rising.
// - pin zero sense bits 1:0 use the same encoding.
// - pins zero and one are sampled before edges are detected.
// - pin two edges captured without the I/O clock; 50 ns pulses count.
// - enables at bits 7,6,5 serve pins one, zero, two, gated globally.
// - each pin has its own request line and vector.
// - events set flags at bits 7,6,5; enabled flags request the CPU.
// - flags clear on service or when software writes a one.
// - pins in low-level mode always read their flag as cleared.
// - deep sleep with pin two disabled blocks its buffer and may set flag.
module epi_ext_irq
    import epi_pkg::*;
#(
    parameter int unsigned STARTUP_CYC = `EPI_STARTUP_CYC_DEF
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // interrupt pins: index 0 pin zero, 1 pin one, 2 pin two
    input wire logic ext_pin_zero,
    input wire logic ext_pin_one,
    input wire logic ext_pin_two_async,
    // I/O register port
    input wire logic [5:0] io_addr,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // CPU side
    input wire logic cpu_status_word_i,
    input wire logic [2:0] irq_ack,
    output logic [2:0] irq_req,
    // power state
    input wire logic io_clk_run,
    input wire logic pwr_down,
    input wire logic sleep_deep,
    output logic wake_req
);

    typedef struct packed {
        logic [1:0] sense0;
        logic [1:0] sense1;
        logic async_sel;
        logic [2:0] en;
        logic [2:0] flag;
        logic [1:0] prev01;
        logic prev2;
        logic primed;
        logic [4:0] wdt_cnt;
        logic [15:0] su_cnt;
        epi_wake_type wake;
        logic wake_q;
        logic [7:0] rdata;
    } epi_state_type;

    epi_state_type st_q;
    epi_state_type st_d;

    localparam logic [4:0] WDT_LAST = 5'(`EPI_WDT_TICK_CYC - 1);
    localparam logic [15:0] SU_LAST = 16'(STARTUP_CYC - 1);

    logic [2:0] pin_s;
    logic eff2;
    logic wdt_tick;
    logic [2:0] set_ev;
    logic [2:0] lvl_mode;
    logic [2:0] lvl_req;
    logic any_low;
    logic wr_flags;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // edge detect by sense code; low level yields no edge event
    function automatic logic sense_edge(input logic [1:0] mode,
                                        input logic prev,
                                        input logic cur);
        logic ev;
        ev = 1'b0;
        unique case (epi_sense_type'(mode))
            SENSE_LOW: ev = 1'b0;
            SENSE_ANY: ev = prev ^ cur;
            SENSE_FALL: ev = prev & ~cur;
            SENSE_RISE: ev = ~prev & cur;
        endcase
        return ev;
    endfunction : sense_edge

    // pack internal per-pin bits into the register byte layout
    function automatic logic [7:0] pack_bits(input logic [2:0] b);
        logic [7:0] r;
        r = `EPI_RST_BYTE;
        r[`EPI_BIT_PIN_ONE] = b[1];
        r[`EPI_BIT_PIN_ZERO] = b[0];
        r[`EPI_BIT_PIN_TWO] = b[2];
        return r;
    endfunction : pack_bits

    function automatic logic [2:0] unpack_bits(input logic [7:0] r);
        return {r[`EPI_BIT_PIN_TWO], r[`EPI_BIT_PIN_ONE],
                r[`EPI_BIT_PIN_ZERO]};
    endfunction : unpack_bits

    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    // pads are read regardless of pin direction, so software can
    // interrupt itself by driving the pin
    epi_sync u_sync (
        .ref_clk (ref_clk),
        .rst (rst),
        .pin_raw ({ext_pin_two_async, ext_pin_one, ext_pin_zero}),
        .pin_sync (pin_s)
    );

    // combinational decode of events and levels
    always_comb
    begin
        // disabled pin two in deep sleep sees a forced low
        eff2 = (sleep_deep && !st_q.en[2]) ? 1'b0 : pin_s[2];
        wdt_tick = (st_q.wdt_cnt == WDT_LAST);
        lvl_mode[0] = (st_q.sense0 == SENSE_LOW);
        lvl_mode[1] = (st_q.sense1 == SENSE_LOW);
        lvl_mode[2] = 1'b0; // pin two has no level mode
        // edges on pins zero/one only while the I/O clock runs
        set_ev[0] = io_clk_run && st_q.primed &&
                    sense_edge(st_q.sense0, st_q.prev01[0], pin_s[0]);
        set_ev[1] = io_clk_run && st_q.primed &&
                    sense_edge(st_q.sense1, st_q.prev01[1], pin_s[1]);
        // pin two edge path runs without the I/O clock
        set_ev[2] = st_q.primed && (st_q.async_sel ?
                    (~st_q.prev2 & eff2) : (st_q.prev2 & ~eff2));
        // level requests are held off during start-up
        lvl_req[0] = lvl_mode[0] && !pin_s[0] && st_q.wake != WK_STARTUP;
        lvl_req[1] = lvl_mode[1] && !pin_s[1] && st_q.wake != WK_STARTUP;
        lvl_req[2] = 1'b0;
        any_low = |(lvl_mode[1:0] & st_q.en[1:0] & ~pin_s[1:0]);
        wr_flags = io_we && io_addr == `EPI_ADDR_FLAGS;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.wake_q = 1'b0;
        st_d.primed = 1'b1;
        // sampled values feed edge detection one cycle later
        if (io_clk_run)
        begin
            st_d.prev01 = pin_s[1:0];
        end
        st_d.prev2 = eff2;
        st_d.wdt_cnt = wdt_tick ? 5'h00 : st_q.wdt_cnt + 5'h01;

        // register writes
        if (io_we)
        begin
            unique case (io_addr)
                `EPI_ADDR_ASYNC_SENSE:
                    st_d.async_sel = io_wdata[`EPI_BIT_ASYNC_EDGE];
                `EPI_ADDR_PIN_SENSE:
                begin
                    st_d.sense1 = io_wdata[`EPI_PIN_ONE_SENSE_HI:
                                           `EPI_PIN_ONE_SENSE_LO];
                    st_d.sense0 = io_wdata[`EPI_PIN_ZERO_SENSE_HI:
                                           `EPI_PIN_ZERO_SENSE_LO];
                end
                `EPI_ADDR_ENABLES:
                    st_d.en = unpack_bits(io_wdata);
                default:
                begin
                end
            endcase
        end

        // flags: clear by service or write-one, zeros keep
        // a new event in the clear cycle wins
        st_d.flag = (st_q.flag & ~irq_ack &
                     ~(wr_flags ? unpack_bits(io_wdata) : 3'h0)) | set_ev;
        // low-level pins hold their flag cleared
        st_d.flag = st_d.flag & ~lvl_mode;

        // power-down wake sequencer: samples on the watchdog tick, start-up counted in ref_clk cycles
        unique case (st_q.wake)
            WK_RUN:
            begin
                if (pwr_down && wdt_tick && any_low)
                begin
                    st_d.wake = WK_SAMPLE; // first sample
                end
            end
            WK_SAMPLE:
            begin
                if (wdt_tick)
                begin
                    st_d.wake = any_low ? WK_STARTUP : WK_RUN;
                    st_d.wake_q = any_low;
                    st_d.su_cnt = 16'h0000;
                end
            end
            WK_STARTUP:
            begin
                // level interrupt only if still low when this ends
                st_d.su_cnt = st_q.su_cnt + 16'h0001;
                if (st_q.su_cnt == SU_LAST)
                begin
                    st_d.wake = WK_RUN;
                end
            end
        endcase
        // pin two edge wakes from any sleep without the I/O clock
        if (set_ev[2] && st_q.en[2] && (pwr_down || !io_clk_run) &&
            st_q.wake == WK_RUN)
        begin
            st_d.wake_q = 1'b1;
            st_d.wake = WK_STARTUP;
            st_d.su_cnt = 16'h0000;
        end

        // registered read data
        if (io_re)
        begin
            unique case (io_addr)
                `EPI_ADDR_ASYNC_SENSE:
                    st_d.rdata = {1'b0, st_q.async_sel, 6'h00};
                `EPI_ADDR_PIN_SENSE:
                    st_d.rdata = {4'h0, st_q.sense1, st_q.sense0};
                `EPI_ADDR_FLAGS:
                    st_d.rdata = pack_bits(st_q.flag & ~lvl_mode);
                `EPI_ADDR_ENABLES:
                    st_d.rdata = pack_bits(st_q.en);
                default:
                    st_d.rdata = `EPI_RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q.sense0 <= `EPI_RST_SENSE;
            st_q.sense1 <= `EPI_RST_SENSE;
            st_q.async_sel <= 1'b0;
            st_q.en <= `EPI_RST_BITS3;
            st_q.flag <= `EPI_RST_BITS3;
            st_q.prev01 <= 2'h3;
            st_q.prev2 <= 1'b1;
            st_q.primed <= 1'b0;
            st_q.wdt_cnt <= 5'h00;
            st_q.su_cnt <= 16'h0000;
            st_q.wake <= WK_RUN;
            st_q.wake_q <= 1'b0;
            st_q.rdata <= `EPI_RST_BYTE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs: one request line per vector
    // ------------------------------------------------------------------
    // level pins request straight from the pin; edges from the flag
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            irq_req[i] = cpu_status_word_i && st_q.en[i] &&
                         (lvl_mode[i] ? lvl_req[i] : st_q.flag[i]);
        end
    end

    assign io_rdata = st_q.rdata;
    assign wake_req = st_q.wake_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_global_gate: assert property (!cpu_status_word_i |-> irq_req == 3'h0)
        else $error("request raised with global enable clear");

    a_level_request: assert property (st_q.en[0] && cpu_status_word_i &&
        st_q.sense0 == SENSE_LOW && !pin_s[0] && st_q.wake == WK_RUN
        |-> irq_req[0])
        else $error("low level on pin zero not requesting");

    a_level_flag_clear: assert property (st_q.sense1 == SENSE_LOW &&
        $past(st_q.sense1) == SENSE_LOW |-> st_q.flag[1] == 1'b0)
        else $error("pin one flag set in low level mode");

    a_write_one_clear: assert property (wr_flags && io_wdata[6] &&
        !set_ev[0] |=> !st_q.flag[0])
        else $error("writing one did not clear pin zero flag");

    a_write_zero_keep: assert property (wr_flags && !io_wdata[5] &&
        st_q.flag[2] && !irq_ack[2] |=> st_q.flag[2])
        else $error("writing zero cleared pin two flag");

    a_pin_two_rise: assert property (st_q.async_sel && st_q.primed &&
        !st_q.prev2 && eff2 |=> st_q.flag[2])
        else $error("rising edge on pin two not flagged");

    a_edge_needs_clk: assert property (!io_clk_run &&
        st_q.sense0 != SENSE_LOW |=> !(st_q.flag[0] && !$past(st_q.flag[0])))
        else $error("pin zero edge flagged without I/O clock");

    a_any_change: assert property (io_clk_run && st_q.primed &&
        st_q.sense1 == SENSE_ANY && st_q.prev01[1] != pin_s[1]
        |=> st_q.flag[1])
        else $error("change on pin one not flagged");

    a_two_samples: assert property (st_q.wake == WK_RUN && pwr_down &&
        wdt_tick && any_low |=> st_q.wake == WK_SAMPLE && !wake_req)
        else $error("wake taken on a single sample");

    a_startup_bound: assert property (st_q.wake == WK_STARTUP |->
        st_q.su_cnt <= SU_LAST && irq_req[1:0] ==
        (st_q.flag[1:0] & st_q.en[1:0] & ~lvl_mode[1:0] &
        {2{cpu_status_word_i}}))
        else $error("level request during start-up");

    c_level_wake: cover property (st_q.wake == WK_SAMPLE ##[1:30] wake_req);
    c_pin_two_wake: cover property (!io_clk_run && set_ev[2] ##1 wake_req);
    c_edge_irq: cover property (set_ev[0] ##1 irq_req[0] ##[1:20] irq_ack[0]);

endmodule : epi_ext_irq

`default_nettype wire

/* File: epi_pin_src.sv */
// epi_pin_src.sv: model of the sources that drive the three interrupt
// pins, whether an outside device or the part's own port driver.
// assumes: the bench calls its tasks just after a rising ref_clk edge.
`timescale 1ns/1ns
`default_nettype none

module epi_pin_src
(
    // clock
    input wire logic ref_clk,
    // pad levels: index 0 pin zero, 1 pin one, 2 pin two
    output var logic [2:0] pins
);
    // pins idle high, as with a pull-up on the pad
    initial pins = 3'h7;

    // ------------------------------------------------------------------
    // level and pulse drivers
    // ------------------------------------------------------------------
    // the same drive serves a pin configured as an output
    task automatic drive(input int idx, input logic lvl);
        pins[idx] = lvl;
    endtask : drive

    // a low held for whole clock periods, never shorter
    task automatic pulse_low(input int idx, input int n_cyc);
        pins[idx] = 1'b0;
        repeat (n_cyc) @(posedge ref_clk);
        #1;
        pins[idx] = 1'b1;
    endtask : pulse_low
endmodule : epi_pin_src

`default_nettype wire

/* File: tb.sv */
// tb.sv: self-checking bench for the external pin interrupt block.
// assumes: epi_pin_src drives the pads; a short start-up count is used.
`timescale 1ns/1ns
`default_nettype none
`include "epi_defs.svh"

module tb;
    import epi_pkg::*;
    localparam int unsigned STARTUP = 4;
    logic ref_clk, rst, io_we, io_re, gie, clk_run, pwr_down, deep;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata;
    logic [2:0] irq_ack, irq_req, pins;
    logic wake_req;
    int mismatches, n_tests, cycles;

    // ------------------------------------------------------------------
    // design, pad sources, clock and timeout
    // ------------------------------------------------------------------
    epi_pin_src src (.ref_clk(ref_clk), .pins(pins));
    epi_ext_irq #(.STARTUP_CYC(STARTUP)) uut (.ref_clk(ref_clk),
        .rst(rst), .ext_pin_zero(pins[0]), .ext_pin_one(pins[1]),
        .ext_pin_two_async(pins[2]), .io_addr(io_addr), .io_we(io_we),
        .io_re(io_re), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .cpu_status_word_i(gie), .irq_ack(irq_ack), .irq_req(irq_req),
        .io_clk_run(clk_run), .pwr_down(pwr_down), .sleep_deep(deep),
        .wake_req(wake_req));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // a whole run takes about 360 cycles; a hang stops far beyond
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        cyc(1);
        io_we = 1'b1;
        io_addr = a;
        io_wdata = v;
        cyc(1);
        io_we = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        cyc(1);
        io_re = 1'b1;
        io_addr = a;
        cyc(1);
        io_re = 1'b0;
        v = io_rdata;
    endtask : rd

    task automatic chk_rd(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check(v, exp);
    endtask : chk_rd

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // reset values, reserved bits, an unmapped place
    task automatic t_regs();
        chk_rd(`EPI_ADDR_FLAGS, 8'h00);
        chk_rd(`EPI_ADDR_ENABLES, 8'h00);
        chk_rd(`EPI_ADDR_PIN_SENSE, 8'h00);
        wr(`EPI_ADDR_ASYNC_SENSE, 8'hff);
        chk_rd(`EPI_ADDR_ASYNC_SENSE, 8'h40);
        wr(`EPI_ADDR_ENABLES, 8'hff);
        chk_rd(`EPI_ADDR_ENABLES, 8'he0);
        wr(6'h10, 8'hff);
        chk_rd(6'h10, 8'h00);
        wr(`EPI_ADDR_ENABLES, 8'h00);
        wr(`EPI_ADDR_ASYNC_SENSE, 8'h00);
    endtask : t_regs

    // every edge code on both synced pins, fall then rise
    task automatic t_edges();
        int b;
        logic ef, er;
        for (int p = 0; p < 2; p++)
            for (int m = 1; m < 4; m++)
            begin
                b = (p == 0) ? 6 : 7;
                ef = (m == 1) || (m == 2);
                er = (m == 1) || (m == 3);
                wr(`EPI_ADDR_PIN_SENSE, 8'(m << (2 * p)));
                wr(`EPI_ADDR_FLAGS, 8'he0);
                src.drive(p, 1'b0);
                cyc(6);
                chk_rd(`EPI_ADDR_FLAGS, 8'(ef) << b);
                wr(`EPI_ADDR_FLAGS, 8'he0);
                src.drive(p, 1'b1);
                cyc(6);
                chk_rd(`EPI_ADDR_FLAGS, 8'(er) << b);
            end
        wr(`EPI_ADDR_FLAGS, 8'he0);
    endtask : t_edges

    // low level on pin zero: request while low, flag reads cleared
    task automatic t_level();
        gie = 1'b1;
        wr(`EPI_ADDR_PIN_SENSE, 8'h0a);
        wr(`EPI_ADDR_ENABLES, 8'h40);
        wr(`EPI_ADDR_PIN_SENSE, 8'h08);
        src.drive(0, 1'b0);
        cyc(20);
        check(8'(irq_req), 8'h01);
        chk_rd(`EPI_ADDR_FLAGS, 8'h00);
        src.drive(0, 1'b1);
        cyc(5);
        check(8'(irq_req), 8'h00);
        wr(`EPI_ADDR_ENABLES, 8'h00);
    endtask : t_level

    // gating, write-zero, service and write-one clears on pin one
    task automatic t_gate();
        gie = 1'b0;
        wr(`EPI_ADDR_PIN_SENSE, 8'h0c);
        wr(`EPI_ADDR_ENABLES, 8'h80);
        src.pulse_low(1, 3);
        cyc(6);
        check(8'(irq_req), 8'h00);
        chk_rd(`EPI_ADDR_FLAGS, 8'h80);
        gie = 1'b1;
        cyc(1);
        check(8'(irq_req), 8'h02);
        wr(`EPI_ADDR_FLAGS, 8'h00);
        chk_rd(`EPI_ADDR_FLAGS, 8'h80);
        irq_ack = 3'h2;
        cyc(1);
        irq_ack = 3'h0;
        cyc(1);
        check(8'(irq_req), 8'h00);
        src.pulse_low(1, 3);
        cyc(6);
        wr(`EPI_ADDR_FLAGS, 8'h80);
        chk_rd(`EPI_ADDR_FLAGS, 8'h00);
        wr(`EPI_ADDR_ENABLES, 8'h00);
    endtask : t_gate

    // pin two with the I/O clock stopped; both edge selects
    task automatic t_async();
        clk_run = 1'b0;
        wr(`EPI_ADDR_PIN_SENSE, 8'h02);
        src.pulse_low(0, 3);
        cyc(6);
        chk_rd(`EPI_ADDR_FLAGS, 8'h00);
        wr(`EPI_ADDR_ENABLES, 8'h20);
        src.drive(2, 1'b0);
        cyc(6);
        check(8'(irq_req), 8'h04);
        wr(`EPI_ADDR_FLAGS, 8'hc0);
        check(8'(irq_req), 8'h04);
        irq_ack = 3'h4;
        cyc(1);
        irq_ack = 3'h0;
        check(8'(irq_req), 8'h00);
        src.drive(2, 1'b1);
        wr(`EPI_ADDR_ENABLES, 8'h00);
        wr(`EPI_ADDR_ASYNC_SENSE, 8'h40);
        wr(`EPI_ADDR_FLAGS, 8'h20);
        wr(`EPI_ADDR_ENABLES, 8'h20);
        src.drive(2, 1'b0);
        cyc(6);
        check(8'(irq_req), 8'h00);
        src.drive(2, 1'b1);
        cyc(6);
        check(8'(irq_req), 8'h04);
        wr(`EPI_ADDR_FLAGS, 8'h20);
        wr(`EPI_ADDR_ENABLES, 8'h00);
        // deep sleep with pin two disabled: buffer drops and comes back,
        // the return reads as a rising edge under the rising select
        deep = 1'b1;
        cyc(3);
        deep = 1'b0;
        cyc(3);
        chk_rd(`EPI_ADDR_FLAGS, 8'h20);
        wr(`EPI_ADDR_FLAGS, 8'h20);
        clk_run = 1'b1;
    endtask : t_async

    // power-down level wake; the low is gone before start-up ends
    task automatic t_wake();
        int n;
        wr(`EPI_ADDR_PIN_SENSE, 8'h00);
        wr(`EPI_ADDR_ENABLES, 8'h40);
        pwr_down = 1'b1;
        clk_run = 1'b0;
        src.drive(0, 1'b0);
        n = 0;
        while (wake_req !== 1'b1 && n < 80)
        begin
            cyc(1);
            n++;
        end
        check(8'(n >= 25 && n < 80), 8'h01);
        src.drive(0, 1'b1);
        pwr_down = 1'b0;
        clk_run = 1'b1;
        for (int i = 0; i < STARTUP + 4; i++)
        begin
            check(8'(irq_req), 8'h00);
            cyc(1);
        end
        wr(`EPI_ADDR_ENABLES, 8'h00);
    endtask : t_wake

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        io_we = 1'b0;
        io_re = 1'b0;
        io_addr = 6'h00;
        io_wdata = 8'h00;
        gie = 1'b0;
        irq_ack = 3'h0;
        clk_run = 1'b1;
        pwr_down = 1'b0;
        deep = 1'b0;
        mismatches = 0;
        n_tests = 0;
        cycles = 0;
        cyc(12);
        rst = 1'b0;
        cyc(3);
        t_regs();
        t_edges();
        t_level();
        t_gate();
        t_async();
        t_wake();
        stop_test();
    end
endmodule : tb

`default_nettype wire
